/* File: sdpdr_defines.svh */
// timing and field constants for the sdram power-down and reset block
`ifndef SDPDR_DEFINES_SVH
`define SDPDR_DEFINES_SVH
`define SDPDR_CLK_PERIOD_NS   10
`define SDPDR_RESET_MIN_NS    100
`define SDPDR_RESET_CYC \
    ((`SDPDR_RESET_MIN_NS + `SDPDR_CLK_PERIOD_NS - 1) / `SDPDR_CLK_PERIOD_NS)
`define SDPDR_PPD_FAST        1'h1
`define SDPDR_WR_FIELD_W      3
`define SDPDR_CNT_W           16
`define SDPDR_CNT_ZERO        16'h0000
`define SDPDR_CNT_ONE         16'h0001
`endif

/* File: sdpdr_pkg.sv */
// types for the sdram power-down and reset block
package sdpdr_pkg;
    typedef enum logic [5:0] {
        SDPDR_RESET = 6'h01,
        SDPDR_IDLE  = 6'h02,
        SDPDR_ACT   = 6'h04,
        SDPDR_APD   = 6'h08,
        SDPDR_PPDF  = 6'h10,
        SDPDR_PPDS  = 6'h20
    } sdpdr_state_t;
endpackage : sdpdr_pkg

/* File: sdpdr_sync.sv */
// two-flop synchroniser, one flop pair per bit of d
`timescale 1ns/10ps
module sdpdr_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_r;
    logic [W-1:0] q_r;
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            always_ff @(posedge clk) begin
                meta_r[i] <= d[i];
                q_r[i]    <= meta_r[i];
            end
        end
    endgenerate
    assign q = q_r;
endmodule : sdpdr_sync

/* File: sdpdr_core.sv */
// power-down entry, residency, exit and reset state tracker
`timescale 1ns/10ps
`include "sdpdr_defines.svh"
module sdpdr_core #(
    parameter int TXP_CYC    = 3,
    parameter int TXPDLL_CYC = 3,
    parameter int TPD_CYC    = 3
) (
    input  wire logic                           clk,
    input  wire logic                           rstn,
    input  wire logic                           reset_pin_n,
    input  wire logic                           cke_pin,
    input  wire logic                           odt_pin,
    input  wire logic                           nop_cmd,
    input  wire logic                           any_bank_open,
    input  wire logic                           ops_busy,
    input  wire logic                           ppd_fast_exit,
    input  wire logic                           dll_disable_mode,
    input  wire logic [`SDPDR_WR_FIELD_W-1:0]   wr_field,
    output sdpdr_pkg::sdpdr_state_t             state,
    output logic                                dll_on,
    output logic                                in_power_down,
    output logic                                outputs_en,
    output logic                                odt_active,
    output logic                                refresh_clear,
    output logic                                dll_cmd_ready,
    output logic                                cmd_ready,
    output logic [`SDPDR_WR_FIELD_W-1:0]        wr_recovery,
    output logic                                in_reset
);
    import sdpdr_pkg::*;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    logic [2:0] pins_s;
    logic       rst_pin_s;
    logic       cke_s;
    logic       odt_s;

    // pins cross from the controller domain
    sdpdr_sync #(.W(3)) u_sync (
        .clk (clk),
        .d   ({reset_pin_n, cke_pin, odt_pin}),
        .q   (pins_s)
    );
    assign rst_pin_s = pins_s[2];
    assign cke_s     = pins_s[1];
    assign odt_s     = pins_s[0];

    sdpdr_state_t               st_r, st_nxt;
    logic [`SDPDR_CNT_W-1:0]    rcnt_r, rcnt_nxt;
    logic [`SDPDR_CNT_W-1:0]    xp_r, xp_nxt;
    logic [`SDPDR_CNT_W-1:0]    xd_r, xd_nxt;
    logic                       dll_r, dll_nxt;
    logic                       pd_r, pd_nxt;
    logic                       oe_r, oe_nxt;
    logic                       odt_r, odt_nxt;
    logic                       rclr_r, rclr_nxt;
    logic                       dlr_r, dlr_nxt;
    logic                       cr_r, cr_nxt;
    logic [`SDPDR_WR_FIELD_W-1:0] wr_r, wr_nxt;
    logic                       pd_state;
    logic                       ns_pd;

    assign pd_state = (st_r == SDPDR_APD) || (st_r == SDPDR_PPDF)
                   || (st_r == SDPDR_PPDS);

    always_comb begin
        st_nxt   = st_r;
        rcnt_nxt = rcnt_r;
        xp_nxt   = (xp_r != `SDPDR_CNT_ZERO) ? xp_r - `SDPDR_CNT_ONE : xp_r;
        xd_nxt   = (xd_r != `SDPDR_CNT_ZERO) ? xd_r - `SDPDR_CNT_ONE : xd_r;
        if (!rst_pin_s) begin
            st_nxt   = SDPDR_RESET;
            rcnt_nxt = `SDPDR_CNT_W'(`SDPDR_RESET_CYC);
            xp_nxt   = `SDPDR_CNT_ZERO;
            xd_nxt   = `SDPDR_CNT_ZERO;
        end else begin
            case (st_r)
                SDPDR_RESET: begin
                    if (rcnt_r != `SDPDR_CNT_ZERO) begin
                        rcnt_nxt = rcnt_r - `SDPDR_CNT_ONE;
                    end else begin
                        st_nxt = SDPDR_IDLE;
                    end
                end
                SDPDR_IDLE, SDPDR_ACT: begin
                    if (!cke_s && nop_cmd && !ops_busy) begin
                        if (any_bank_open) begin
                            st_nxt = SDPDR_APD;
                        end else if (ppd_fast_exit == `SDPDR_PPD_FAST) begin
                            st_nxt = SDPDR_PPDF;
                        end else begin
                            st_nxt = SDPDR_PPDS;
                        end
                    end else begin
                        st_nxt = any_bank_open ? SDPDR_ACT : SDPDR_IDLE;
                    end
                end
                SDPDR_APD, SDPDR_PPDF, SDPDR_PPDS: begin
                    if (cke_s) begin
                        st_nxt = any_bank_open ? SDPDR_ACT : SDPDR_IDLE;
                        xp_nxt = `SDPDR_CNT_W'(TXP_CYC);
                        xd_nxt = (st_r == SDPDR_PPDS)
                               ? `SDPDR_CNT_W'(TXPDLL_CYC)
                               : `SDPDR_CNT_W'(TXP_CYC);
                    end
                end
                default: st_nxt = SDPDR_RESET;
            endcase
        end
        ns_pd    = (st_nxt == SDPDR_APD) || (st_nxt == SDPDR_PPDF)
                || (st_nxt == SDPDR_PPDS);
        pd_nxt   = ns_pd;
        dll_nxt  = (st_nxt != SDPDR_PPDS) && (st_nxt != SDPDR_RESET);
        oe_nxt   = (st_nxt != SDPDR_RESET) && !ns_pd;
        odt_nxt  = odt_s && (st_nxt != SDPDR_RESET) && dll_nxt
                && !dll_disable_mode;
        rclr_nxt = (st_nxt == SDPDR_RESET);
        cr_nxt   = !ns_pd && (st_nxt != SDPDR_RESET)
                && (xp_nxt == `SDPDR_CNT_ZERO);
        dlr_nxt  = cr_nxt && (xd_nxt == `SDPDR_CNT_ZERO);
        wr_nxt   = wr_field;
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            st_r   <= SDPDR_RESET;
            rcnt_r <= `SDPDR_CNT_W'(`SDPDR_RESET_CYC);
            xp_r   <= `SDPDR_CNT_ZERO;
            xd_r   <= `SDPDR_CNT_ZERO;
            dll_r  <= 1'h0;
            pd_r   <= 1'h0;
            oe_r   <= 1'h0;
            odt_r  <= 1'h0;
            rclr_r <= 1'h1;
            dlr_r  <= 1'h0;
            cr_r   <= 1'h0;
            wr_r   <= '0;
        end else begin
            st_r   <= st_nxt;
            rcnt_r <= rcnt_nxt;
            xp_r   <= xp_nxt;
            xd_r   <= xd_nxt;
            dll_r  <= dll_nxt;
            pd_r   <= pd_nxt;
            oe_r   <= oe_nxt;
            odt_r  <= odt_nxt;
            rclr_r <= rclr_nxt;
            dlr_r  <= dlr_nxt;
            cr_r   <= cr_nxt;
            wr_r   <= wr_nxt;
        end
    end

    assign state         = st_r;
    assign dll_on        = dll_r;
    assign in_power_down = pd_r;
    assign outputs_en    = oe_r;
    assign odt_active    = odt_r;
    assign refresh_clear = rclr_r;
    assign dll_cmd_ready = dlr_r;
    assign cmd_ready     = cr_r;
    assign wr_recovery   = wr_r;
    assign in_reset      = rclr_r;

    sequence pd_exit_s;
        pd_state && rst_pin_s && cke_s;
    endsequence

    // left power-down, commands held off for exactly the exit latency
    sequence pd_left_s;
        !pd_r && !cr_r ##TXP_CYC cr_r;
    endsequence

    reset_entry_a: assert property (!rst_pin_s |=>
        st_r == SDPDR_RESET && !oe_r && !odt_r)
        else $error("pin reset did not force reset state");
    apd_entry_a: assert property (
        (st_r == SDPDR_ACT || st_r == SDPDR_IDLE) && rst_pin_s && !cke_s
        && nop_cmd && !ops_busy && any_bank_open
        |=> st_r == SDPDR_APD && dll_r)
        else $error("open bank did not enter active power-down");
    ppd_entry_a: assert property (
        (st_r == SDPDR_ACT || st_r == SDPDR_IDLE) && rst_pin_s && !cke_s
        && nop_cmd && !ops_busy && !any_bank_open
        |=> pd_r && st_r != SDPDR_APD)
        else $error("closed banks did not enter precharge power-down");
    slow_dll_a: assert property (st_r == SDPDR_PPDS |-> !dll_r)
        else $error("dll on in slow exit power-down");
    apd_dll_a: assert property (st_r == SDPDR_APD |-> dll_r)
        else $error("dll off in active power-down");
    pd_exit_a: assert property (pd_exit_s |=> pd_left_s)
        else $error("power-down exit not taken");
    reset_hold_a: assert property (
        $rose(st_r == SDPDR_RESET) |-> (!oe_r && rclr_r) [*8])
        else $error("reset state too short");
    no_odt_dll_a: assert property (dll_disable_mode |=> !odt_r)
        else $error("termination on while dll disabled");
endmodule : sdpdr_core

/* File: sdpdr_ctrl_model.sv */
// controller-side pin model driving cke, reset, command and odt
`timescale 1ns/10ps
module sdpdr_ctrl_model #(
    parameter int TPD = 3
) (
    input  wire logic clk,
    output logic      cke_pin,
    output logic      reset_pin_n,
    output logic      nop_cmd,
    output logic      odt_pin
);
    int low_cnt;
    initial begin
        cke_pin = 1'h1;
        reset_pin_n = 1'h1;
        nop_cmd = 1'h1;
        odt_pin = 1'h0;
        low_cnt = 0;
    end
    always @(posedge clk) low_cnt <= cke_pin ? 0 : low_cnt + 1;
    task cke_low;
        @(posedge clk);
        // entries never follow a write, so the early drop is unused
        cke_pin <= 1'h0;
    endtask : cke_low
    // cke then stays high until the next entry
    task cke_high;
        @(posedge clk);
        while (low_cnt < TPD + 1) @(posedge clk);
        cke_pin <= 1'h1;
    endtask : cke_high
    task reset_pulse;
        @(posedge clk);
        cke_pin <= 1'h0;
        reset_pin_n <= 1'h0;
        repeat (10) @(posedge clk);
        reset_pin_n <= 1'h1;
        @(posedge clk);
        cke_pin <= 1'h1;
    endtask : reset_pulse
    task set_odt(input logic v);
        @(posedge clk);
        odt_pin <= v;
    endtask : set_odt
    task set_nop(input logic v);
        @(posedge clk);
        nop_cmd <= v;
    endtask : set_nop
endmodule : sdpdr_ctrl_model

/* File: sdram_power_down_and_reset_test.sv */
// self-checking bench for the power-down and reset tracker
`timescale 1ns/10ps
module sdram_power_down_and_reset_test;
    import sdpdr_pkg::*;
    localparam int TXP = 3;
    localparam int TXPDLL = 6;
    logic         clk, rstn, any_bank_open, ops_busy, ppd_fast_exit;
    logic         dll_disable_mode;
    logic [2:0]   wr_field, wr_recovery;
    wire logic    cke_pin, reset_pin_n, nop_cmd, odt_pin;
    sdpdr_state_t state;
    logic         dll_on, in_power_down, outputs_en, odt_active;
    logic         refresh_clear, dll_cmd_ready, cmd_ready, in_reset;
    int           errors, compares, n, m;
    sdpdr_ctrl_model #(.TPD(3)) ctrl (.clk(clk), .cke_pin(cke_pin),
        .reset_pin_n(reset_pin_n), .nop_cmd(nop_cmd), .odt_pin(odt_pin));
    sdpdr_core #(.TXP_CYC(TXP), .TXPDLL_CYC(TXPDLL), .TPD_CYC(3)) dut (
        .clk(clk), .rstn(rstn), .reset_pin_n(reset_pin_n),
        .cke_pin(cke_pin), .odt_pin(odt_pin), .nop_cmd(nop_cmd),
        .any_bank_open(any_bank_open), .ops_busy(ops_busy),
        .ppd_fast_exit(ppd_fast_exit), .dll_disable_mode(dll_disable_mode),
        .wr_field(wr_field), .state(state), .dll_on(dll_on),
        .in_power_down(in_power_down), .outputs_en(outputs_en),
        .odt_active(odt_active), .refresh_clear(refresh_clear),
        .dll_cmd_ready(dll_cmd_ready), .cmd_ready(cmd_ready),
        .wr_recovery(wr_recovery), .in_reset(in_reset));
    task check(input logic [5:0] seen, input logic [5:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : check
    task wait_st(input sdpdr_state_t s);
        for (int i = 0; i < 30 && state !== s; i++) @(negedge clk);
        check(6'(state), 6'(s));
    endtask : wait_st
    task wrap_up;
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : wrap_up
    task t_reset;
        @(negedge clk);
        check(6'({in_reset, refresh_clear, outputs_en}), 6'h06);
        wait_st(SDPDR_IDLE);
        ctrl.set_odt(1'h1);
        repeat (12) @(negedge clk);
        check(6'(odt_active), 6'h01);
        @(posedge clk);
        dll_disable_mode <= 1'h1;
        repeat (3) @(negedge clk);
        check(6'(odt_active), 6'h00);
        @(posedge clk);
        dll_disable_mode <= 1'h0;
        ctrl.set_odt(1'h0);
    endtask : t_reset
    task t_pd(input logic open, input logic fast, input sdpdr_state_t s);
        @(posedge clk);
        any_bank_open <= open;
        ppd_fast_exit <= fast;
        ctrl.cke_low();
        wait_st(s);
        check(6'(dll_on), 6'(open | fast));
        check(6'({in_power_down, outputs_en}), 6'h02);
        ctrl.cke_high();
        wait_st(open ? SDPDR_ACT : SDPDR_IDLE);
        check(6'(cmd_ready), 6'h00);
        n = 0;
        for (m = 0; m < 20 && dll_cmd_ready !== 1'h1; m++) begin
            @(negedge clk);
            if (cmd_ready !== 1'h1) n++;
        end
        // the exit cycle itself was the first low one, checked above
        check(6'(n + 1), 6'(TXP));
        n = (open | fast) ? TXP : TXPDLL;
        check(6'(m), 6'(n));
    endtask : t_pd
    task t_refuse;
        @(posedge clk);
        ops_busy <= 1'h1;
        any_bank_open <= 1'h0;
        ctrl.cke_low();
        repeat (6) @(negedge clk);
        check(6'(in_power_down), 6'h00);
        check(6'(state), 6'(SDPDR_IDLE));
        ctrl.cke_high();
        repeat (5) @(posedge clk);
        ops_busy <= 1'h0;
        ctrl.set_nop(1'h0);
        ctrl.cke_low();
        repeat (6) @(negedge clk);
        check(6'(in_power_down), 6'h00);
        check(6'(state), 6'(SDPDR_IDLE));
        ctrl.cke_high();
        // let the synchronised cke rise before nop returns
        repeat (3) @(posedge clk);
        ctrl.set_nop(1'h1);
    endtask : t_refuse
    task t_pd_reset;
        @(posedge clk);
        any_bank_open <= 1'h1;
        ctrl.cke_low();
        wait_st(SDPDR_APD);
        fork
            ctrl.reset_pulse();
            begin
                repeat (6) @(negedge clk);
                wait_st(SDPDR_RESET);
                check(6'({outputs_en, odt_active, refresh_clear}),
                      6'h01);
            end
        join
        wait_st(SDPDR_ACT);
    endtask : t_pd_reset
    task t_wr;
        for (int i = 0; i < 8; i++) begin
            @(posedge clk);
            wr_field <= 3'(i);
            repeat (2) @(negedge clk);
            check(6'(wr_recovery), 6'(i));
        end
    endtask : t_wr
    initial begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end
    initial begin
        #100000;
        errors++;
        wrap_up();
    end
    initial begin
        {rstn, any_bank_open, ops_busy, ppd_fast_exit} = 4'h0;
        dll_disable_mode = 1'h0;
        wr_field = 3'h0;
        errors = 0;
        compares = 0;
        repeat (6) @(posedge clk);
        rstn <= 1'h1;
        t_reset();
        t_pd(1'h1, 1'h0, SDPDR_APD);
        t_pd(1'h1, 1'h1, SDPDR_APD);
        t_pd(1'h0, 1'h1, SDPDR_PPDF);
        t_pd(1'h0, 1'h0, SDPDR_PPDS);
        t_refuse();
        t_pd_reset();
        t_wr();
        wrap_up();
    end
endmodule : sdram_power_down_and_reset_test
